// >>> src/vbm_host_port.sv
// Host port and message buffers of the vehicle bus controller.
// Assumes a bus engine on i_mclk that delivers received bytes and takes transmit bytes.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module vbm_host_port
  import vbm_pkg::*;
#(
  parameter int DEPTH = VBM_MSG_BYTES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  input  wire logic        i_host_port_select_low,
  input  wire logic        i_host_port_select_high,
  input  wire logic        i_coding_select,
  input  wire logic        i_osc_8mhz,
  input  wire logic        i_ifr_enable,
  input  wire logic [7:0]  i_node_address_straps,
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_mosi,
  input  wire logic        i_spi_cs_n,
  output logic             o_spi_miso,
  output logic             o_spi_miso_oe,
  input  wire logic        i_tx_message_strobe,
  output logic             o_tx_buffer_full,
  output logic             o_rx_msg_waiting,
  input  wire logic        i_rx_host_ready,
  input  wire logic        i_flush,
  output logic             o_rx_msg_irq,
  output logic             o_tx_error_flag,
  output vbm_coding_t      o_coding,
  output logic             o_tx_req,
  output logic      [7:0]  o_tx_byte,
  output logic             o_tx_last,
  input  wire logic        i_tx_take,
  input  wire logic        i_tx_bus_idle,
  input  wire logic        i_tx_arb_lost,
  input  wire logic        i_tx_error,
  input  wire logic        i_tx_frame_end,
  input  wire logic        i_tx_ifr_seen,
  input  wire vbm_rx_t     i_rx,
  output logic             o_ifr_req,
  output logic      [7:0]  o_ifr_byte,
  input  wire logic        i_ifr_sent,
  input  wire logic        i_ifr_arb_lost
);

  // ==========================================================================
  // Pin synchronisers: every outside level passes two flops first.
  localparam int SW = 19;
  // Idle levels: clock and select high, so no false edge follows reset.
  localparam logic [SW-1:0] PIN_IDLE = 19'h50000;
  logic [SW-1:0] pin_s1_reg;
  logic [SW-1:0] pin_s2_reg;
  logic [SW-1:0] pin_raw;
  logic          sck_d_reg;
  logic          strobe_d_reg;
  logic          flush_d_reg;
  logic          cs_d_reg;

  assign pin_raw = {i_spi_sck, i_spi_mosi, i_spi_cs_n, i_tx_message_strobe, i_flush,
                    i_rx_host_ready, i_host_port_select_high, i_host_port_select_low,
                    i_coding_select, i_osc_8mhz, i_ifr_enable, i_node_address_straps};

  // Second stage samples the first flop; edge history only ever looks at the second flop.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_reg   <= PIN_IDLE;
      pin_s2_reg   <= PIN_IDLE;
      sck_d_reg    <= 1'b1;
      strobe_d_reg <= 1'b0;
      flush_d_reg  <= 1'b0;
      cs_d_reg     <= 1'b1;
    end else begin
      pin_s1_reg   <= pin_raw;
      pin_s2_reg   <= pin_s1_reg;
      sck_d_reg    <= pin_s2_reg[18];
      strobe_d_reg <= pin_s2_reg[15];
      flush_d_reg  <= pin_s2_reg[14];
      cs_d_reg     <= pin_s2_reg[16];
    end
  end

  wire       sck_s     = pin_s2_reg[18];
  wire       mosi_s    = pin_s2_reg[17];
  wire       cs_n_s    = pin_s2_reg[16];
  wire       strobe_s  = pin_s2_reg[15];
  wire       flush_s   = pin_s2_reg[14];
  wire       ready_s   = pin_s2_reg[13];
  wire [1:0] sel_s     = pin_s2_reg[12:11];
  wire       cod_s     = pin_s2_reg[10];
  wire       osc_s     = pin_s2_reg[9];
  wire       ifr_s     = pin_s2_reg[8];
  wire [7:0] addr_s    = pin_s2_reg[7:0];

  // ==========================================================================
  // Strap decode. Port select is level sensitive and followed continuously.
  vbm_host_mode_t host_mode;
  vbm_rate_t      rate;
  assign host_mode = sel_s == 2'b00 ? VBM_HOST_ENH_SPI :
                     sel_s == 2'b10 ? VBM_HOST_HS_SPI  :
                     sel_s == 2'b01 ? VBM_HOST_HS_SCI  : VBM_HOST_TEST;
  assign rate      = (osc_s && cod_s) ? VBM_RATE_41K7 :
                     (osc_s == cod_s) ? VBM_RATE_10K4 : VBM_RATE_20K8;
  wire enh     = host_mode == VBM_HOST_ENH_SPI;
  wire hs      = host_mode == VBM_HOST_HS_SPI || host_mode == VBM_HOST_HS_SCI;
  wire host_on = enh || hs;

  // Node address is caught once, in the cycle after the straps settle past reset.
  logic [7:0] node_addr_reg;
  logic [1:0] addr_wait_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      node_addr_reg <= 8'h00;
      addr_wait_reg <= 2'h0;
      o_coding      <= '0;
    end else begin
      if (addr_wait_reg != 2'h3) addr_wait_reg <= addr_wait_reg + 2'h1;
      if (addr_wait_reg == 2'h2) node_addr_reg <= addr_s;
      o_coding <= '{host_mode: host_mode, pwm: cod_s, rate: rate, ifr_enable: ifr_s};
    end
  end

  // ==========================================================================
  // Serial slave, clock idle high; host samples on rising edges, we shift on falling.
  logic [7:0] shin_reg;
  logic [7:0] shout_reg;
  logic [2:0] bit_reg;
  logic       pair_reg;
  logic [7:0] hold_reg;
  wire        sck_rise  = sck_s && !sck_d_reg;
  wire        sck_fall  = !sck_s && sck_d_reg;
  wire        byte_done = sck_rise && !cs_n_s && bit_reg == VBM_BIT_LAST;
  wire [7:0]  rx_in     = {shin_reg[6:0], mosi_s};
  vbm_status_t status;
  logic [7:0]  rx_out;
  logic [7:0]  next_out;
  // First byte of a pair carries status, the second the visible receive byte.
  assign next_out  = (enh && !pair_reg) ? {1'b0, status} : rx_out;
  wire status_sent = sck_fall && !cs_n_s && bit_reg == 3'h0 && enh && !pair_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shin_reg  <= 8'h00;
      shout_reg <= 8'h00;
      bit_reg   <= 3'h0;
      pair_reg  <= 1'b0;
      hold_reg  <= 8'h00;
    end else if (cs_n_s || !host_on) begin
      bit_reg  <= 3'h0;
      pair_reg <= 1'b0;
    end else begin
      if (sck_fall) shout_reg <= bit_reg == 3'h0 ? next_out : {shout_reg[6:0], 1'b0};
      if (sck_rise) begin
        shin_reg <= rx_in;
        bit_reg  <= bit_reg + 3'h1;
      end
      if (byte_done && enh) begin
        pair_reg <= !pair_reg;
        if (!pair_reg) hold_reg <= rx_in;
      end
    end
  end
  assign o_spi_miso    = shout_reg[7];
  assign o_spi_miso_oe = !cs_n_s && host_on;
  wire cs_fall = !cs_n_s && cs_d_reg;

  // ==========================================================================
  // Host actions decoded from commands (enhanced) or from pins (handshake).
  wire cmd_ok    = byte_done && enh && pair_reg;
  wire [7:0] cmd = rx_in;
  wire hs_flush  = hs && flush_s && !flush_d_reg;
  wire tx_put    = (cmd_ok && (cmd == VBM_CMD_TX_LOAD || cmd == VBM_CMD_TX_LOAD_LAST)) ||
                   (byte_done && hs && strobe_s);
  wire [7:0] tx_put_byte = enh ? hold_reg : rx_in;
  wire tx_close  = (cmd_ok && cmd == VBM_CMD_TX_LOAD_LAST) ||
                   (hs && !strobe_s && strobe_d_reg);
  wire tx_flush  = (cmd_ok && cmd == VBM_CMD_TX_FLUSH) || hs_flush;
  wire rx_adv    = (cmd_ok && cmd == VBM_CMD_RX_NEXT) ||
                   (byte_done && hs && ready_s);
  wire rx_flush  = (cmd_ok && cmd == VBM_CMD_RX_FLUSH) || hs_flush;
  wire set_code  = cmd_ok && cmd == VBM_CMD_SET_CODE;
  wire set_mask  = cmd_ok && cmd == VBM_CMD_SET_MASK;

  // ==========================================================================
  // Acceptance filter registers, written by the register port or by commands.
  logic [7:0] address_match_code_reg;
  logic [7:0] address_match_mask_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      address_match_code_reg <= VBM_CODE_RST;
      address_match_mask_reg <= VBM_MASK_RST;
    end else begin
      if (i_reg_wr && i_reg_addr == VBM_ADDR_CODE) address_match_code_reg <= i_reg_wdata[7:0];
      else if (set_code) address_match_code_reg <= hold_reg;
      if (i_reg_wr && i_reg_addr == VBM_ADDR_MASK) address_match_mask_reg <= i_reg_wdata[7:0];
      else if (set_mask) address_match_mask_reg <= hold_reg;
    end
  end

  // ==========================================================================
  // Receive side: two alternating buffers, one visible to the host.
  logic [7:0] rx_mem [2][DEPTH];
  logic [3:0] rx_len_reg [2];
  logic [1:0] rx_full_reg;
  logic       rd_sel_reg;
  logic       wr_sel_reg;
  logic [3:0] rd_idx_reg;
  logic [3:0] wr_idx_reg;
  logic       rx_on_reg;
  wire        visible   = rx_full_reg[rd_sel_reg];
  wire        rd_last   = rd_idx_reg == rx_len_reg[rd_sel_reg] - 4'h1;
  wire        release_s = visible && host_on && (rx_flush || (rx_adv && rd_last));
  wire        both_full = &rx_full_reg;
  wire        tgt_bad   = enh && wr_idx_reg == VBM_TGT_INDEX &&
                          ((i_rx.data ^ address_match_code_reg) & address_match_mask_reg) != 8'h00;
  wire        rx_store  = rx_on_reg && i_rx.valid && !i_rx.ifr && !tgt_bad &&
                          wr_idx_reg < 4'(DEPTH);
  wire        rx_done   = rx_on_reg && i_rx.end_ok && wr_idx_reg != 4'h0;
  assign rx_out = visible ? rx_mem[rd_sel_reg][rd_idx_reg] : 8'h00;

  // Buffer memory carries no reset; occupancy flags say what is valid.
  always_ff @(posedge i_mclk) begin
    if (rx_store) rx_mem[wr_sel_reg][wr_idx_reg] <= i_rx.data;
  end

  // Frame capture; a frame starting while both buffers hold messages is dropped.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_on_reg  <= 1'b0;
      wr_sel_reg <= 1'b0;
      wr_idx_reg <= 4'h0;
      rx_len_reg <= '{default: 4'h0};
    end else if (i_rx.start) begin
      rx_on_reg  <= !both_full;
      wr_sel_reg <= visible ? !rd_sel_reg : rd_sel_reg;
      wr_idx_reg <= 4'h0;
    end else if (rx_on_reg) begin
      if (i_rx.abort || rx_done || (i_rx.valid && tgt_bad)) rx_on_reg <= 1'b0;
      if (rx_store) wr_idx_reg <= wr_idx_reg + 4'h1;
      if (rx_done) rx_len_reg[wr_sel_reg] <= wr_idx_reg;
    end
  end

  // Occupancy; filling and releasing never touch the same buffer at once.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_full_reg <= 2'b00;
      rd_sel_reg  <= 1'b0;
      rd_idx_reg  <= 4'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (rx_done && wr_sel_reg == 1'(b)) rx_full_reg[b] <= 1'b1;
        else if (release_s && rd_sel_reg == 1'(b)) rx_full_reg[b] <= 1'b0;
      end
      if (release_s) begin
        rd_sel_reg <= !rd_sel_reg;
        rd_idx_reg <= 4'h0;
      end else if (rx_adv && visible) begin
        rd_idx_reg <= rd_idx_reg + 4'h1;
      end
    end
  end
  assign o_rx_msg_waiting = hs && visible;
  assign o_rx_msg_irq     = enh && visible;

  // ==========================================================================
  // Transmit side: a single message buffer and its retry sequencer.
  typedef enum logic [1:0] {VBM_TX_LOAD, VBM_TX_WAIT, VBM_TX_SEND} vbm_tx_state_t;
  vbm_tx_state_t tx_state_reg;
  logic [7:0] tx_mem [DEPTH];
  logic [3:0] tx_len_reg;
  logic [3:0] tx_idx_reg;
  logic [7:0] tx_crc_reg;
  logic [1:0] tx_try_reg;
  logic       tx_done_reg;
  logic       tx_err_reg;

  // One step of the frame check over a byte, most significant bit first.
  function automatic logic [7:0] vbm_crc_step(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ VBM_CRC_POLY) : (c << 1);
    return c;
  endfunction : vbm_crc_step

  wire tx_open   = tx_state_reg == VBM_TX_LOAD && host_on;
  wire tx_write  = tx_put && tx_open && tx_len_reg < 4'(DEPTH);
  wire tx_fill   = tx_write && tx_len_reg == 4'(DEPTH - 1);
  wire tx_commit = tx_open && (tx_fill || (tx_close && (tx_write || tx_len_reg != 4'h0)));
  wire sending   = tx_state_reg == VBM_TX_SEND;
  wire ifr_miss  = i_tx_frame_end && ifr_s && !i_tx_ifr_seen;
  wire tx_fault  = sending && (i_tx_error || ifr_miss);
  wire tx_ok     = sending && i_tx_frame_end && !ifr_miss;
  wire tx_giveup = tx_fault && tx_try_reg == VBM_RETRY_MAX;

  always_ff @(posedge i_mclk) begin
    if (tx_write) tx_mem[tx_len_reg] <= tx_put_byte;
  end

  // Sequencer: wait for an idle bus, send, and retry after errors.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state_reg <= VBM_TX_LOAD;
      tx_len_reg   <= 4'h0;
      tx_idx_reg   <= 4'h0;
      tx_crc_reg   <= VBM_CRC_INIT;
      tx_try_reg   <= 2'h0;
    end else if (tx_flush && host_on) begin
      tx_state_reg <= VBM_TX_LOAD;
      tx_len_reg   <= 4'h0;
      tx_try_reg   <= 2'h0;
    end else begin
      case (tx_state_reg)
        VBM_TX_LOAD: begin
          if (tx_write) tx_len_reg <= tx_len_reg + 4'h1;
          if (tx_commit) tx_state_reg <= VBM_TX_WAIT;
        end
        VBM_TX_WAIT: begin
          if (i_tx_bus_idle) begin
            tx_state_reg <= VBM_TX_SEND;
            tx_idx_reg   <= 4'h0;
            tx_crc_reg   <= VBM_CRC_INIT;
          end
        end
        VBM_TX_SEND: begin
          if (tx_ok || tx_giveup) begin
            tx_state_reg <= VBM_TX_LOAD;
            tx_len_reg   <= 4'h0;
            tx_try_reg   <= 2'h0;
          end else if (tx_fault) begin
            tx_state_reg <= VBM_TX_WAIT;
            tx_try_reg   <= tx_try_reg + 2'h1;
          end else if (i_tx_arb_lost) begin
            tx_state_reg <= VBM_TX_WAIT;  // Lost arbitration costs no attempt.
          end else if (i_tx_take && tx_idx_reg <= tx_len_reg) begin
            tx_idx_reg <= tx_idx_reg + 4'h1;
            if (tx_idx_reg < tx_len_reg) begin
              tx_crc_reg <= vbm_crc_step(tx_crc_reg, tx_mem[tx_idx_reg]);
            end
          end
        end
        default: tx_state_reg <= VBM_TX_LOAD;
      endcase
    end
  end

  // The check byte follows the last data byte; the host never supplies it.
  assign o_tx_req  = sending && tx_idx_reg <= tx_len_reg;
  assign o_tx_last = tx_idx_reg == tx_len_reg;
  assign o_tx_byte = o_tx_last ? (tx_crc_reg ^ VBM_CRC_XOR) : tx_mem[tx_idx_reg];
  assign o_tx_buffer_full = hs && tx_state_reg != VBM_TX_LOAD;
  assign o_tx_error_flag  = tx_err_reg;

  // Sticky outcome flags; they clear when status is read, a new event wins.
  wire st_read = (i_reg_rd && i_reg_addr == VBM_ADDR_STATUS) || status_sent;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_done_reg <= 1'b0;
      tx_err_reg  <= 1'b0;
    end else begin
      tx_done_reg <= tx_ok || (tx_done_reg && !st_read);
      tx_err_reg  <= tx_giveup || (tx_err_reg && !st_read);
    end
  end

  assign status = '{rx_both_full: both_full, tx_error: tx_err_reg, tx_done: tx_done_reg,
                    tx_sending: sending, tx_full: tx_state_reg != VBM_TX_LOAD,
                    rx_last: visible && rd_last, rx_avail: visible};

  // ==========================================================================
  // In-frame response: one byte of node address, no check byte, never retried.
  logic ifr_pend_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ifr_pend_reg <= 1'b0;
    end else if (i_rx.start || i_ifr_sent || i_ifr_arb_lost) begin
      ifr_pend_reg <= 1'b0;
    end else if (i_rx.end_ok && ifr_s && !sending) begin
      ifr_pend_reg <= 1'b1;
    end
  end
  assign o_ifr_req  = ifr_pend_reg;
  assign o_ifr_byte = node_addr_reg;

  // ==========================================================================
  // Register port; read data stand in the cycle after the strobe.
  logic [31:0] rd_mux;
  assign rd_mux = i_reg_addr == VBM_ADDR_CODE   ? {24'h000000, address_match_code_reg} :
                  i_reg_addr == VBM_ADDR_MASK   ? {24'h000000, address_match_mask_reg} :
                  i_reg_addr == VBM_ADDR_STATUS ? {25'h0000000, status} :
                  i_reg_addr == VBM_ADDR_STRAPS ? {18'h00000, o_coding, node_addr_reg} :
                  32'h00000000;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) o_reg_rdata <= 32'h00000000;
    else          o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
  end

  wire unused_ok = &{1'b0, cs_fall, addr_s};

endmodule : vbm_host_port
`default_nettype wire

// >>> src/vbm_pkg.sv
// Constants, carrier types and enumerations of the vehicle bus message buffer host port.
// Assumes one 200 MHz system clock; the bus engine outside uses the same clock.
// Operation
// - Enhanced serial exchanges are two consecutive 8-bit transfers forming one pair.
// - First transfer: host byte may be junk, device returns its status byte.
// - Second transfer: host sends a command, device returns a possibly invalid data byte.
// - Port select decode: 00 enhanced, 01 handshake serial, 10 handshake async, 11 test; code takes high,low 10 as handshake serial, 01 as async.
// - Coding select with oscillator picks PWM or VPW and one of three bit rates.
// - With response enabled, answer frames with one node address byte, no check byte.
// - With response enabled, a missing response to our frame is a transmit error.
// - Response byte losing arbitration is not retried within the same frame.
// - With response disabled, neither send nor expect any response byte.
// - Node address straps are captured once when reset is released.
// - Transmit buffer holds one message of up to 11 bytes.
// - Device computes and appends the frame check byte after the data.
// - While a complete message is held, further host transmit bytes are ignored.
// - Flush pin in handshake modes or discard command drops the pending transmit message.
// - Handshake uses strobe and full pin; enhanced uses commands and status byte.
// - Two 11-byte receive buffers alternate; host sees only one at a time.
// - With both receive buffers full, new bus frames are ignored.
// - Handshake: message-waiting pin rises on full message; host ready precedes each byte.
// - Enhanced mode raises the message interrupt when a complete message lands.
// - Flush pin or receive-discard command drops the visible received message.
// - Own frames may be received, but response bytes never enter a receive buffer.
// - Enhanced mode compares target address with code under mask; mismatch drops frame.
// - On transmit error wait for idle bus, retry twice more, then drop and report.
package vbm_pkg;

  // ==========================================================================
  // Sizes and register map.
  localparam int          VBM_MSG_BYTES   = 11;
  localparam logic [7:0]  VBM_ADDR_CODE   = 8'h00;
  localparam logic [7:0]  VBM_ADDR_MASK   = 8'h04;
  localparam logic [7:0]  VBM_ADDR_STATUS = 8'h08;
  localparam logic [7:0]  VBM_ADDR_STRAPS = 8'h0C;
  localparam logic [7:0]  VBM_CODE_RST    = 8'h00;
  localparam logic [7:0]  VBM_MASK_RST    = 8'h00;
  localparam logic [1:0]  VBM_RETRY_MAX   = 2'h2;

  // ==========================================================================
  // Enhanced serial command codes, sent in the second byte of a pair.
  localparam logic [7:0]  VBM_CMD_TX_LOAD      = 8'h10;
  localparam logic [7:0]  VBM_CMD_TX_LOAD_LAST = 8'h11;
  localparam logic [7:0]  VBM_CMD_TX_FLUSH     = 8'h12;
  localparam logic [7:0]  VBM_CMD_RX_NEXT      = 8'h20;
  localparam logic [7:0]  VBM_CMD_RX_FLUSH     = 8'h21;
  localparam logic [7:0]  VBM_CMD_SET_CODE     = 8'h30;
  localparam logic [7:0]  VBM_CMD_SET_MASK     = 8'h31;

  // ==========================================================================
  // Frame check byte (polynomial, preset, final inversion), last serial bit index and target byte index.
  localparam logic [7:0]  VBM_CRC_POLY  = 8'h1D;
  localparam logic [7:0]  VBM_CRC_INIT  = 8'hFF;
  localparam logic [7:0]  VBM_CRC_XOR   = 8'hFF;
  localparam logic [2:0]  VBM_BIT_LAST  = 3'h7;
  localparam logic [3:0]  VBM_TGT_INDEX = 4'h1;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    VBM_HOST_ENH_SPI, VBM_HOST_HS_SPI, VBM_HOST_HS_SCI, VBM_HOST_TEST
  } vbm_host_mode_t;

  typedef enum logic [1:0] {
    VBM_RATE_10K4, VBM_RATE_20K8, VBM_RATE_41K7
  } vbm_rate_t;

  typedef struct packed {
    vbm_host_mode_t host_mode;
    logic           pwm;
    vbm_rate_t      rate;
    logic           ifr_enable;
  } vbm_coding_t;

  typedef struct packed {
    logic       rx_both_full;
    logic       tx_error;
    logic       tx_done;
    logic       tx_sending;
    logic       tx_full;
    logic       rx_last;
    logic       rx_avail;
  } vbm_status_t;

  typedef struct packed {
    logic       start;
    logic       valid;
    logic [7:0] data;
    logic       ifr;
    logic       end_ok;
    logic       abort;
  } vbm_rx_t;

endpackage : vbm_pkg

// >>> bench/vbm_host_port_props.sv
// Checker of the host port outputs.
// Assumes the bind at its foot reaches the one host port.
`timescale 1ns/10ps
`default_nettype none
module vbm_host_port_props
  import vbm_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic [7:0]  i_node_address_straps,
  input wire logic        o_spi_miso_oe,
  input wire logic        o_rx_msg_irq,
  input wire vbm_coding_t o_coding,
  input wire logic        o_ifr_req,
  input wire logic [7:0]  o_ifr_byte
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  vbm_host_mode_t m;
  assign m = o_coding.host_mode;
  // Read data stand one cycle, so stale data never pass for fresh.
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("stale read data");
  a_test_quiet: assert property (m == VBM_HOST_TEST |-> !o_spi_miso_oe)
    else $error("port active in test");
  a_irq_enh: assert property (o_rx_msg_irq |-> m == VBM_HOST_ENH_SPI)
    else $error("irq outside enhanced");
  a_ifr_addr: assert property (o_ifr_req |-> o_ifr_byte == i_node_address_straps)
    else $error("bad response byte");
  a_ifr_off: assert property ($rose(o_ifr_req) |-> o_coding.ifr_enable)
    else $error("response while off");
  a_rate_pwm: assert property (o_coding.rate == VBM_RATE_41K7 |-> o_coding.pwm)
    else $error("fast rate without pwm");
  a_rate_vpw: assert property (o_coding.rate == VBM_RATE_10K4 |-> !o_coding.pwm)
    else $error("slow rate with pwm");
  a_rate_legal: assert property (o_coding.rate != 2'h3)
    else $error("unknown rate");
  cover property (o_rx_msg_irq);
  cover property (o_ifr_req);
  cover property (o_coding.rate == VBM_RATE_41K7);
endmodule : vbm_host_port_props
bind vbm_host_port vbm_host_port_props u_props (.i_mclk, .i_rst_n, .i_reg_rd,
  .o_reg_rdata, .i_node_address_straps, .o_spi_miso_oe, .o_rx_msg_irq, .o_coding,
  .o_ifr_req, .o_ifr_byte);
`default_nettype wire

// >>> bench/vbm_spi_host.sv
// Host model: SPI master, clock idle high, data out on fall, in on rise.
// Assumes the host port samples these pins with its own clock.
`timescale 1ns/10ps
`default_nettype none
module vbm_spi_host (
  output var logic o_sck,
  output var logic o_mosi,
  output var logic o_cs_n,
  input wire logic i_miso
);
  initial {o_sck, o_mosi, o_cs_n} = 3'h7;
  // One pair under one select: data and status, then command and data.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #40 o_sck = 1'b0;
      o_mosi = tx[i];
      #40 o_sck = 1'b1;
      rx[i] = i_miso;
    end
    #40 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;  // A released line must not repeat its last bit.
  endtask : xfer
endmodule : vbm_spi_host
`default_nettype wire

// >>> bench/vbm_host_port_test.sv
// Bench of the host port: registers, receive filter and flush, transmit.
// Assumes the SPI host model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module vbm_host_port_test;
  import vbm_pkg::*;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_tx_take = 1'b0;
  logic i_tx_frame_end = 1'b0, i_ifr_sent = 1'b0, lo = 1'b0;  // Selects held still.
  logic [7:0] i_reg_addr = 8'h0;
  logic [31:0] i_reg_wdata = 32'h0;
  vbm_rx_t i_rx = '0;
  wire logic [31:0] o_reg_rdata;
  wire logic [7:0] o_tx_byte;
  wire logic o_spi_miso, o_rx_msg_irq, o_tx_req, o_tx_last, o_ifr_req, sck, mosi, cs_n;
  int mismatches = 0, n_checks = 0, n_ifr = 0;
  logic ifr_en = 1'b1;  // Response enable, dropped before the second frame.
  initial forever #2.5 i_mclk = ~i_mclk;
  // Partner answers each response request once and counts the responses sent.
  always @(posedge i_mclk) begin
    i_ifr_sent <= o_ifr_req & !i_ifr_sent;
    if (o_ifr_req & !i_ifr_sent) n_ifr++;
  end
  vbm_spi_host spi (.o_sck(sck), .o_mosi(mosi), .o_cs_n(cs_n), .i_miso(o_spi_miso));
  vbm_host_port dut (.i_mclk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_host_port_select_low(lo), .i_host_port_select_high(lo),
    .i_coding_select(1'b1), .i_osc_8mhz(1'b1), .i_ifr_enable(ifr_en),
    .i_node_address_straps(8'h55), .i_spi_sck(sck), .i_spi_mosi(mosi), .i_spi_cs_n(cs_n),
    .o_spi_miso, .o_spi_miso_oe(), .i_tx_message_strobe(lo), .o_tx_buffer_full(),
    .o_rx_msg_waiting(), .i_rx_host_ready(lo), .i_flush(lo), .o_rx_msg_irq,
    .o_tx_error_flag(), .o_coding(), .o_tx_req, .o_tx_byte, .o_tx_last, .i_tx_take,
    .i_tx_bus_idle(1'b1), .i_tx_arb_lost(lo), .i_tx_error(lo), .i_tx_frame_end,
    .i_tx_ifr_seen(1'b1), .i_rx, .o_ifr_req, .o_ifr_byte(), .i_ifr_sent, .i_ifr_arb_lost(lo));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // A read is judged in the one cycle its data stand.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge i_mclk) {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
    @(posedge i_mclk) {i_reg_wr, i_reg_rd} <= 2'h0;
    #1 if (!w) chk(o_reg_rdata, e);
  endtask : bus
  // Target byte is the second stored byte; a pass is then flushed by command.
  task automatic t_frame(input logic [7:0] tgt, input logic exp);
    logic [15:0] r;
    for (int i = 0; i < 5; i++) begin
      @(posedge i_mclk) i_rx <= '{i == 0, i inside {[1:2]}, i == 2 ? tgt : 8'h68, 0, i == 3, 0};
    end
    repeat (4) @(posedge i_mclk);
    chk(o_rx_msg_irq, exp);
    spi.xfer({8'h00, VBM_CMD_RX_FLUSH}, r);
    repeat (4) @(posedge i_mclk);
    chk(o_rx_msg_irq, 1'b0);
  endtask : t_frame
  task automatic t_tx;
    logic [15:0] r;
    spi.xfer({8'h3C, VBM_CMD_TX_LOAD_LAST}, r);
    for (int i = 0; i < 99 && !o_tx_req; i++) @(posedge i_mclk);
    chk({o_tx_req, o_tx_byte}, 9'h13C);
    if (!o_tx_req) end_sim;
    @(posedge i_mclk) i_tx_take <= 1'b1;
    @(posedge i_mclk) i_tx_take <= 1'b0;
    #1 chk({o_tx_last, o_tx_byte}, 9'h1ED);
  endtask : t_tx
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    bus(1'b1, VBM_ADDR_CODE, 32'h5A, 32'h0);
    bus(1'b1, VBM_ADDR_MASK, 32'hF0, 32'h0);
    bus(1'b0, VBM_ADDR_CODE, 32'h0, 32'h5A);
    bus(1'b0, 8'h10, 32'h0, 32'h0);
    bus(1'b0, VBM_ADDR_STRAPS, 32'h0, 32'h00000D55);
    t_frame(8'h53, 1'b1);
    chk(n_ifr, 32'h1);
    ifr_en <= 1'b0;
    t_frame(8'hA5, 1'b0);
    chk(n_ifr, 32'h1);
    t_tx;
    end_sim;
  end
endmodule : vbm_host_port_test
`default_nettype wire
